//--- hw/swe_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the event block
// Assumes: byte-wide runtime registers decoded by the host I/O logic upstream
// Notes:   offsets are byte addresses in the runtime block
`ifndef SWE_DEFINES_SVH
`define SWE_DEFINES_SVH

// register offsets
`define SWE_OFS_WD_UNITS    8'h52
`define SWE_OFS_WD_VALUE    8'h53
`define SWE_OFS_WD_CONFIG   8'h54
`define SWE_OFS_WD_CONTROL  8'h55
`define SWE_OFS_PIN_CTRL    8'h56
`define SWE_OFS_SMI_STS1    8'h60
`define SWE_OFS_SYSMGMT_STATUS_TWO    8'h61
`define SWE_OFS_SMI_STS3    8'h62
`define SWE_OFS_SMI_STS4    8'h63
`define SWE_OFS_SMI_STS5    8'h64
`define SWE_OFS_SMI_EN1     8'h68
`define SWE_OFS_SMI_EN2     8'h69
`define SWE_OFS_SMI_EN3     8'h6a
`define SWE_OFS_SMI_EN4     8'h6b
`define SWE_OFS_SMI_EN5     8'h6c
`define SWE_OFS_MISC_STS    8'h70
`define SWE_OFS_WAKE_STS    8'h71
`define SWE_OFS_WAKE_EN     8'h72
`define SWE_OFS_WAKE_STS3   8'h73

// field positions
`define SWE_UNITS_MINUTES   7
`define SWE_CFG_KBD_EN      0
`define SWE_CFG_MOUSE_EN    1
`define SWE_CFG_JOY_EN      2
`define SWE_CTRL_STATUS     0
`define SWE_CTRL_FORCE      2
`define SWE_PIN_POLARITY    1
`define SWE_PIN_OPEN_DRAIN  7
`define SWE_EN2_TO_PIN      7
`define SWE_EN2_TO_SERIRQ   6
`define SWE_EN2_TO_WAKE     5
`define SWE_STS2_INFRARED   0
`define SWE_STS2_WATCHDOG   1
`define SWE_STS3_DEVINT     3

// reset values
`define SWE_RST_WD_VALUE    8'h00
`define SWE_RST_PIN_CTRL    8'h82

// timing
`define SWE_SECOND_NS       1000000000
`define SWE_CLK_PERIOD_NS   10
`define SWE_SECOND_CYCLES   (`SWE_SECOND_NS / `SWE_CLK_PERIOD_NS)
`define SWE_SECS_PER_MINUTE 60

`endif

//--- hw/swe_pkg.sv
// Purpose: shared types of the event block
// Assumes: nothing beyond the defines header
// Notes:   types only; numbers live in swe_defines.svh
package swe_pkg;
  typedef enum logic [0:0] {
    SWE_WD_HALTED  = 1'b0,
    SWE_WD_RUNNING = 1'b1
  } swe_wd_state_type;

  typedef logic [7:0] swe_byte_type;
endpackage

//--- hw/swe_prescaler.sv
// Purpose: second and minute ticks for the watchdog
// Assumes: free-running mclk
// Notes:   ticks are one-cycle pulses; the minute tick coincides with a second tick
`timescale 1ns/1ps
`default_nettype none
`include "swe_defines.svh"

module swe_prescaler #(
  parameter int SEC_CYCLES = `SWE_SECOND_CYCLES,
  parameter int SECS_PER_MIN = `SWE_SECS_PER_MINUTE
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  output logic      second_tick,
  output logic      minute_tick
);
  import swe_pkg::*;

  initial begin
    if (SEC_CYCLES < 2 || SECS_PER_MIN < 1 || SECS_PER_MIN > 255) begin
      $error("swe_prescaler: unusable tick parameters");
    end
  end

  logic [31:0] cyc_reg;
  logic [31:0] cyc_next;
  logic [7:0]  sec_reg;
  logic [7:0]  sec_next;
  logic        sec_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // counters roll over independently of any watchdog load, so the first
  // unit after a load may be up to one unit short
  always_comb begin
    sec_wrap = (cyc_reg == 32'(SEC_CYCLES - 1));
    cyc_next = sec_wrap ? 32'h0000_0000 : cyc_reg + 32'h0000_0001;
    sec_next = sec_reg;
    if (sec_wrap) begin
      sec_next = (sec_reg == 8'(SECS_PER_MIN - 1)) ? 8'h00 : sec_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_reg <= 32'h0000_0000;
      sec_reg <= 8'h00;
    end else begin
      cyc_reg <= cyc_next;
      sec_reg <= sec_next;
    end
  end

  assign second_tick = sec_wrap; // RQ22
  assign minute_tick = sec_wrap && (sec_reg == 8'(SECS_PER_MIN - 1)); // RQ22

endmodule
`default_nettype wire

//--- hw/swe_event_core.sv
// Purpose: either-edge gpio events, watchdog and group system-management interrupt
// Assumes: host runtime register strobes are one-cycle and synchronous to mclk
// Notes:   gpio and event inputs are taken as synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "swe_defines.svh"

// Behaviour
// RQ1 - six gpio inputs trigger on both edges
// RQ2 - either-edge overrides pad controls; readback keeps polarity
// RQ3 - either-edge pin raises only when enabled and selected
// RQ4 - transitions set wake and sysmgmt status; write-one clears
// RQ5 - misc register holds one both-edge bit per pin
// RQ6 - status records regardless of enables or mode
// RQ7 - timeout 1..255, unit bit 7 at 0x52
// RQ8 - zero value disables; zero after reset
// RQ9 - nonzero value write reloads and starts counting
// RQ10 - at zero counter halts, status sets
// RQ11 - host sets or clears timeout status anytime; a reload event or expiry in the same cycle overrides the written bit
// RQ12 - enabled kbd, mouse, 0x201 events reload, clear status
// RQ13 - mapped interrupt request follows timeout status
// RQ14 - force bit zeroes count, sets status, self-clears
// RQ15 - pin polarity and drive type; default low open-drain
// RQ16 - group is OR of enabled sources; pin gate
// RQ17 - enable bit 6 sends group on serial IRQ2
// RQ18 - enable bit 5 feeds group into wake status
// RQ19 - gpio status edge follows polarity; write-one clears
// RQ20 - gpio and tach status ANDed with enables
// RQ21 - peripheral sources live; infrared clears on read
// RQ22 - watchdog steps on prescaled second or minute
module swe_event_core #(
  parameter int GPIO_BITS = 24,
  parameter int EE_POS [6] = '{1, 2, 12, 14, 7, 15},
  parameter int SEC_CYCLES = `SWE_SECOND_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire swe_pkg::swe_byte_type  reg_wdata,
  output swe_pkg::swe_byte_type       reg_rdata,
  input  wire logic [GPIO_BITS-1:0]   gpio_in,
  input  wire logic [GPIO_BITS-1:0]   gpio_polarity,
  input  wire logic [5:0]             either_edge_select,
  output logic [5:0]                  either_edge_override,
  output logic [5:0]                  either_edge_readback,
  input  wire logic [7:0]             periph_src1,
  input  wire logic [2:0]             periph_src2,
  input  wire logic                   infrared_event,
  input  wire logic                   kbd_irq_event,
  input  wire logic                   mouse_irq_event,
  input  wire logic                   joy_port_access,
  output logic                        wdt_irq_request,
  output logic [3:0]                  wdt_irq_channel,
  output logic                        group_sysmgmt_internal,
  output logic                        group_sysmgmt_pin_out,
  output logic                        group_sysmgmt_pin_oe,
  output logic                        serirq_irq2_request,
  output logic                        device_interrupt_status,
  output logic                        wake_edge_request
);
  import swe_pkg::*;

  initial begin
    if (GPIO_BITS != 24) begin
      $error("swe_event_core: three status registers need exactly 24 gpio bits");
    end
    for (int j = 0; j < 6; j++) begin
      if (EE_POS[j] < 0 || EE_POS[j] >= GPIO_BITS) begin
        $error("swe_event_core: either-edge position out of range");
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  swe_byte_type     units_reg, units_next, value_reg, value_next;
  swe_byte_type     cfg_reg, cfg_next, pin_ctrl_reg, pin_ctrl_next;
  swe_byte_type     count_reg, count_next, rdata_reg, rdata_next;
  swe_wd_state_type wd_state_reg, wd_state_next;
  logic             wd_status_reg, wd_status_next;
  logic [7:0]       en1_reg, en1_next, en2_reg, en2_next;
  logic [23:0]      en345_reg, en345_next, sts345_reg, sts345_next;
  logic [23:0]      prev_reg, prev_next;
  logic             primed_reg;
  logic [5:0]       misc_reg, misc_next, wake_sts_reg, wake_sts_next, wake_en_reg, wake_en_next;
  logic             ir_reg, ir_next, devint_reg, devint_next;
  logic             pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next, serirq_reg, serirq_next;

  logic [23:0] set345, ee_mask, ee_sel24;
  logic [5:0]  ee_edge;
  logic        sec_tick, min_tick, unit_tick, reload_evt, group;
  logic        wr_value, wr_ctrl, force_wr;
  logic [7:0]  sts2_view;

  swe_prescaler #(
    .SEC_CYCLES   (SEC_CYCLES),
    .SECS_PER_MIN (`SWE_SECS_PER_MINUTE)
  ) u_prescaler (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .second_tick (sec_tick),
    .minute_tick (min_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // either-edge pin map
  always_comb begin
    ee_mask  = 24'h00_0000;
    ee_sel24 = 24'h00_0000;
    for (int j = 0; j < 6; j++) begin
      ee_mask[EE_POS[j]]  = 1'b1;
      ee_sel24[EE_POS[j]] = either_edge_select[j];
    end
  end

  // per-bit edge detect; edges only counted once the previous sample is real
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi++) begin : g_edge
      logic rise_pol;
      assign rise_pol = primed_reg && ((gpio_in[gi] ^ gpio_polarity[gi]) && !(prev_reg[gi] ^ gpio_polarity[gi]));
      assign set345[gi] = ee_sel24[gi] ? (primed_reg && (gpio_in[gi] != prev_reg[gi])) : rise_pol; // RQ19 RQ4 RQ1
    end
    for (gi = 0; gi < 6; gi++) begin : g_ee
      assign ee_edge[gi] = primed_reg && (gpio_in[EE_POS[gi]] != prev_reg[EE_POS[gi]]); // RQ1
      assign either_edge_readback[gi] = gpio_in[EE_POS[gi]] ^ gpio_polarity[EE_POS[gi]]; // RQ2
    end
  endgenerate

  assign either_edge_override = either_edge_select; // RQ2

  ////////////////////////////////////////////////////////////////////////////
  // group interrupt; either-edge pins only contribute when in that mode
  assign sts2_view = {3'b000, periph_src2, wd_status_reg, ir_reg};
  always_comb begin
    group = |(periph_src1 & en1_reg) // RQ21 RQ16
          | |({periph_src2, wd_status_reg, ir_reg} & en2_reg[4:0]) // RQ21 RQ16
          | |(sts345_reg & en345_reg & (~ee_mask | ee_sel24)); // RQ20 RQ3
  end
  assign group_sysmgmt_internal = group;

  ////////////////////////////////////////////////////////////////////////////
  // register writes, w1c status and event capture; set always beats clear
  assign wr_value = reg_wr && (reg_addr == `SWE_OFS_WD_VALUE);
  assign wr_ctrl  = reg_wr && (reg_addr == `SWE_OFS_WD_CONTROL);
  assign force_wr = wr_ctrl && reg_wdata[`SWE_CTRL_FORCE];
  always_comb begin
    units_next    = units_reg;
    value_next    = value_reg;
    cfg_next      = cfg_reg;
    pin_ctrl_next = pin_ctrl_reg;
    en1_next      = en1_reg;
    en2_next      = en2_reg;
    en345_next    = en345_reg;
    wake_en_next  = wake_en_reg;
    sts345_next   = sts345_reg;
    misc_next     = misc_reg;
    wake_sts_next = wake_sts_reg;
    ir_next       = ir_reg;
    devint_next   = devint_reg;
    if (reg_wr) begin
      case (reg_addr)
        `SWE_OFS_WD_UNITS:  units_next = reg_wdata; // RQ7
        `SWE_OFS_WD_VALUE:  value_next = reg_wdata;
        `SWE_OFS_WD_CONFIG: cfg_next = reg_wdata;
        `SWE_OFS_PIN_CTRL:  pin_ctrl_next = reg_wdata;
        `SWE_OFS_SMI_EN1:   en1_next = reg_wdata;
        `SWE_OFS_SMI_EN2:   en2_next = reg_wdata;
        `SWE_OFS_SMI_EN3:   en345_next[7:0] = reg_wdata;
        `SWE_OFS_SMI_EN4:   en345_next[15:8] = reg_wdata;
        `SWE_OFS_SMI_EN5:   en345_next[23:16] = reg_wdata;
        `SWE_OFS_WAKE_EN:   wake_en_next = reg_wdata[5:0];
        `SWE_OFS_SMI_STS3:  sts345_next[7:0] = sts345_reg[7:0] & ~reg_wdata; // RQ19
        `SWE_OFS_SMI_STS4:  sts345_next[15:8] = sts345_reg[15:8] & ~reg_wdata; // RQ19
        `SWE_OFS_SMI_STS5:  sts345_next[23:16] = sts345_reg[23:16] & ~reg_wdata; // RQ19
        `SWE_OFS_MISC_STS:  misc_next = misc_reg & ~reg_wdata[5:0]; // RQ5
        `SWE_OFS_WAKE_STS:  wake_sts_next = wake_sts_reg & ~reg_wdata[5:0]; // RQ4
        `SWE_OFS_WAKE_STS3: devint_next = devint_reg & ~reg_wdata[`SWE_STS3_DEVINT];
        default: ;
      endcase
    end
    if (reg_rd && reg_addr == `SWE_OFS_SYSMGMT_STATUS_TWO) begin
      ir_next = 1'b0; // RQ21
    end
    sts345_next   = sts345_next | set345; // RQ6 RQ19
    misc_next     = misc_next | ee_edge; // RQ5 RQ6
    wake_sts_next = wake_sts_next | ee_edge; // RQ4 RQ6
    ir_next       = ir_next | infrared_event;
    devint_next   = devint_next | (group && en2_reg[`SWE_EN2_TO_WAKE]); // RQ18
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: force beats reload beats countdown; a zero value never expires
  assign unit_tick  = units_reg[`SWE_UNITS_MINUTES] ? min_tick : sec_tick; // RQ7 RQ22
  assign reload_evt = (kbd_irq_event && cfg_reg[`SWE_CFG_KBD_EN])
                    || (mouse_irq_event && cfg_reg[`SWE_CFG_MOUSE_EN])
                    || (joy_port_access && cfg_reg[`SWE_CFG_JOY_EN]); // RQ12
  always_comb begin
    count_next     = count_reg;
    wd_state_next  = wd_state_reg;
    wd_status_next = wd_status_reg;
    if (wr_ctrl) begin
      wd_status_next = reg_wdata[`SWE_CTRL_STATUS]; // RQ11
    end
    if (force_wr) begin
      count_next     = 8'h00; // RQ14
      wd_state_next  = SWE_WD_HALTED;
      wd_status_next = 1'b1; // RQ14
    end else if (wr_value || reload_evt) begin
      count_next    = wr_value ? reg_wdata : value_reg; // RQ9 RQ12
      wd_state_next = ((wr_value ? reg_wdata : value_reg) != 8'h00) ? SWE_WD_RUNNING : SWE_WD_HALTED; // RQ8
      if (reload_evt) begin
        wd_status_next = 1'b0; // RQ12
      end
    end else begin
      case (wd_state_reg)
        SWE_WD_HALTED: ;
        SWE_WD_RUNNING: begin
          if (unit_tick) begin
            count_next = count_reg - 8'h01; // RQ22
            if (count_reg == 8'h01) begin
              wd_state_next  = SWE_WD_HALTED; // RQ10
              wd_status_next = 1'b1; // RQ10
            end
          end
        end
        default: wd_state_next = SWE_WD_HALTED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, serial slot and read mux
  always_comb begin
    logic act;
    act          = group && en2_reg[`SWE_EN2_TO_PIN]; // RQ16
    pin_out_next = act ^ pin_ctrl_reg[`SWE_PIN_POLARITY]; // RQ15
    pin_oe_next  = pin_ctrl_reg[`SWE_PIN_OPEN_DRAIN] ? !pin_out_next : 1'b1; // RQ15
    if (pin_ctrl_reg[`SWE_PIN_OPEN_DRAIN]) begin
      pin_out_next = 1'b0;
    end
    serirq_next = group && en2_reg[`SWE_EN2_TO_SERIRQ]; // RQ17
    prev_next   = gpio_in;
    case (reg_addr)
      `SWE_OFS_WD_UNITS:   rdata_next = units_reg;
      `SWE_OFS_WD_VALUE:   rdata_next = value_reg;
      `SWE_OFS_WD_CONFIG:  rdata_next = cfg_reg;
      `SWE_OFS_WD_CONTROL: rdata_next = {7'h00, wd_status_reg}; // force bit reads back as zero
      `SWE_OFS_PIN_CTRL:   rdata_next = pin_ctrl_reg;
      `SWE_OFS_SMI_STS1:   rdata_next = periph_src1;
      `SWE_OFS_SYSMGMT_STATUS_TWO:   rdata_next = sts2_view;
      `SWE_OFS_SMI_STS3:   rdata_next = sts345_reg[7:0];
      `SWE_OFS_SMI_STS4:   rdata_next = sts345_reg[15:8];
      `SWE_OFS_SMI_STS5:   rdata_next = sts345_reg[23:16];
      `SWE_OFS_SMI_EN1:    rdata_next = en1_reg;
      `SWE_OFS_SMI_EN2:    rdata_next = en2_reg;
      `SWE_OFS_SMI_EN3:    rdata_next = en345_reg[7:0];
      `SWE_OFS_SMI_EN4:    rdata_next = en345_reg[15:8];
      `SWE_OFS_SMI_EN5:    rdata_next = en345_reg[23:16];
      `SWE_OFS_MISC_STS:   rdata_next = {2'b00, misc_reg};
      `SWE_OFS_WAKE_STS:   rdata_next = {2'b00, wake_sts_reg};
      `SWE_OFS_WAKE_EN:    rdata_next = {2'b00, wake_en_reg};
      `SWE_OFS_WAKE_STS3:  rdata_next = {4'h0, devint_reg, 3'b000};
      default:             rdata_next = 8'h00;
    endcase
    if (!reg_rd) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      units_reg <= 8'h00;
      value_reg <= `SWE_RST_WD_VALUE;
      cfg_reg <= 8'h00;
      pin_ctrl_reg <= `SWE_RST_PIN_CTRL;
      count_reg <= 8'h00;
      rdata_reg <= 8'h00;
      wd_state_reg <= SWE_WD_HALTED;
      wd_status_reg <= 1'b0;
      en1_reg <= 8'h00;
      en2_reg <= 8'h00;
      en345_reg <= 24'h00_0000;
      sts345_reg <= 24'h00_0000;
      prev_reg <= 24'h00_0000;
      primed_reg <= 1'b0;
      misc_reg <= 6'h00;
      wake_sts_reg <= 6'h00;
      wake_en_reg <= 6'h00;
      ir_reg <= 1'b0;
      devint_reg <= 1'b0;
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
      serirq_reg <= 1'b0;
    end else begin
      units_reg <= units_next;
      value_reg <= value_next;
      cfg_reg <= cfg_next;
      pin_ctrl_reg <= pin_ctrl_next;
      count_reg <= count_next;
      rdata_reg <= rdata_next;
      wd_state_reg <= wd_state_next;
      wd_status_reg <= wd_status_next;
      en1_reg <= en1_next;
      en2_reg <= en2_next;
      en345_reg <= en345_next;
      sts345_reg <= sts345_next;
      prev_reg <= prev_next;
      primed_reg <= 1'b1;
      misc_reg <= misc_next;
      wake_sts_reg <= wake_sts_next;
      wake_en_reg <= wake_en_next;
      ir_reg <= ir_next;
      devint_reg <= devint_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      serirq_reg <= serirq_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign wdt_irq_channel = cfg_reg[7:4];
  assign wdt_irq_request = wd_status_reg && (cfg_reg[7:4] != 4'h0); // RQ13
  assign group_sysmgmt_pin_out = pin_out_reg;
  assign group_sysmgmt_pin_oe = pin_oe_reg;
  assign serirq_irq2_request = serirq_reg;
  assign device_interrupt_status = devint_reg;
  assign wake_edge_request = |(wake_sts_reg & wake_en_reg & either_edge_select); // RQ3

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_misc_set;
    ee_edge != 6'h00 |=> (misc_reg & $past(ee_edge)) == $past(ee_edge);
  endproperty
  a_misc_set: assert property (p_misc_set) else $error("misc edge bit not set"); // RQ5

  property p_zero_disables;
    wr_value && reg_wdata == 8'h00 |=> count_reg == 8'h00 && wd_state_reg == SWE_WD_HALTED;
  endproperty
  a_zero_disables: assert property (p_zero_disables) else $error("zero value did not disable"); // RQ8

  property p_load;
    wr_value && reg_wdata != 8'h00 |=> count_reg == $past(reg_wdata) && wd_state_reg == SWE_WD_RUNNING;
  endproperty
  a_load: assert property (p_load) else $error("nonzero value not loaded"); // RQ9

  property p_expire;
    wd_state_reg == SWE_WD_RUNNING && count_reg == 8'h01 && unit_tick && !reload_evt && !reg_wr
      |=> wd_status_reg && count_reg == 8'h00 ##1 (count_reg == 8'h00 || $past(reg_wr) || $past(reload_evt));
  endproperty
  a_expire: assert property (p_expire) else $error("watchdog expiry wrong"); // RQ10

  property p_host_status;
    wr_ctrl && !force_wr && !reload_evt && !(wd_state_reg == SWE_WD_RUNNING && count_reg == 8'h01 && unit_tick)
      |=> wd_status_reg == $past(reg_wdata[`SWE_CTRL_STATUS]);
  endproperty
  a_host_status: assert property (p_host_status) else $error("host status write ignored"); // RQ11

  property p_reload;
    reload_evt && !reg_wr |=> count_reg == value_reg && !wd_status_reg;
  endproperty
  a_reload: assert property (p_reload) else $error("reload event not honoured"); // RQ12

  property p_irq;
    $rose(wd_status_reg) && cfg_reg[7:4] != 4'h0 |-> wdt_irq_request;
  endproperty
  a_irq: assert property (p_irq) else $error("watchdog request missing"); // RQ13

  property p_force;
    force_wr |=> count_reg == 8'h00 && wd_status_reg && wd_state_reg == SWE_WD_HALTED;
  endproperty
  a_force: assert property (p_force) else $error("forced timeout failed"); // RQ14

  property p_pin;
    group && en2_reg[`SWE_EN2_TO_PIN] && !reg_wr |=> pin_ctrl_reg[`SWE_PIN_OPEN_DRAIN] ?
      (pin_oe_reg == pin_ctrl_reg[`SWE_PIN_POLARITY]) : (pin_out_reg == !pin_ctrl_reg[`SWE_PIN_POLARITY]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not asserted"); // RQ16 RQ15

  property p_serirq;
    serirq_irq2_request |-> $past(group) && $past(en2_reg[`SWE_EN2_TO_SERIRQ]);
  endproperty
  a_serirq: assert property (p_serirq) else $error("serial slot without cause"); // RQ17

  property p_devint;
    group && en2_reg[`SWE_EN2_TO_WAKE] |=> device_interrupt_status;
  endproperty
  a_devint: assert property (p_devint) else $error("device interrupt status not set"); // RQ18

  property p_ir_clear;
    reg_rd && reg_addr == `SWE_OFS_SYSMGMT_STATUS_TWO && !infrared_event |=> !ir_reg;
  endproperty
  a_ir_clear: assert property (p_ir_clear) else $error("infrared status not cleared"); // RQ21

  property p_w1c3;
    reg_wr && reg_addr == `SWE_OFS_SMI_STS3 |=> (sts345_reg[7:0] & $past(reg_wdata) & ~$past(set345[7:0])) == 8'h00;
  endproperty
  a_w1c3: assert property (p_w1c3) else $error("gpio status not cleared"); // RQ19

  c_expire: cover property (wd_state_reg == SWE_WD_RUNNING ##1 $rose(wd_status_reg));
  c_force:  cover property (force_wr ##1 wd_status_reg);
  c_pin:    cover property (group && en2_reg[`SWE_EN2_TO_PIN] ##1 group);
  c_misc:   cover property (ee_edge != 6'h00 ##1 misc_reg != 6'h00);

endmodule
`default_nettype wire

//--- bench/swe_host_model.sv
// Purpose: host side of the runtime register strobes
// Assumes: one-cycle strobes, one access at a time
// Notes:   idle write data shows the inverted last value
`timescale 1ns/1ps
`default_nettype none
module swe_host_model (
  input  wire logic             mclk,
  output logic [7:0]            reg_addr,
  output logic                  reg_wr,
  output logic                  reg_rd,
  output swe_pkg::swe_byte_type reg_wdata
);
  import swe_pkg::*;
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'hff;
  end
  // status writes go out whatever the counter is doing
  task automatic wr(input logic [7:0] a, input swe_byte_type d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data must not look valid
  endtask
  // read strobe; data lands one cycle later
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- bench/smi_watchdog_edge_events_bench.sv
// Purpose: self-checking bench of the event core
// Assumes: short second count for speed
// Notes:   read results are checked against a queue of notes
`timescale 1ns/1ps
`default_nettype none
`include "swe_defines.svh"
module smi_watchdog_edge_events_bench;
  import swe_pkg::*;
  logic         mclk, arst_n, rd_d, reg_wr, reg_rd, p;
  logic [7:0]   reg_addr, src1;
  logic [23:0]  gin, gpol;
  logic [5:0]   sel, ovr, rb;
  logic [2:0]   src2;
  logic         ir_ev, kbd_ev, ms_ev, joy_ev, wirq, grp, pout, poe, sirq, devint, wake;
  logic [3:0]   wchan;
  swe_byte_type wdata, rdata, expq[$];
  int           error_cnt, n_tests;
  swe_host_model swe_host_model_inst (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(wdata));
  swe_event_core #(.SEC_CYCLES(10)) swe_event_core_inst (.mclk(mclk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(wdata), .reg_rdata(rdata),
    .gpio_in(gin), .gpio_polarity(gpol), .either_edge_select(sel), .either_edge_override(ovr),
    .either_edge_readback(rb), .periph_src1(src1), .periph_src2(src2), .infrared_event(ir_ev),
    .kbd_irq_event(kbd_ev), .mouse_irq_event(ms_ev), .joy_port_access(joy_ev),
    .wdt_irq_request(wirq), .wdt_irq_channel(wchan), .group_sysmgmt_internal(grp),
    .group_sysmgmt_pin_out(pout), .group_sysmgmt_pin_oe(poe), .serirq_irq2_request(sirq),
    .device_interrupt_status(devint), .wake_edge_request(wake));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // note the expectation before the strobe goes out
  task automatic rd(input logic [7:0] a, input swe_byte_type e);
    expq.push_back(e);
    swe_host_model_inst.rd(a);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // read data settles one cycle after the strobe
  always @(posedge mclk) rd_d <= reg_rd;
  always @(negedge mclk) if (rd_d) check(rdata, expq.pop_front());
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // a hang costs a mismatch
  initial begin
    #50us;
    error_cnt++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(99968));
    p = 1'($urandom);
    {arst_n, ir_ev, kbd_ev, ms_ev, joy_ev, error_cnt, n_tests} = '0;
    {gin, sel, src1, src2} = '0;
    gpol = {20'h0, p, 1'($urandom), 2'h0}; // polarity fixed before reset, no false edge
    idle(4);
    arst_n <= 1'b1;
    src1 <= 8'($urandom); // not enabled, must stay off the group
    src2 <= 3'($urandom);
    rd(`SWE_OFS_WD_VALUE, `SWE_RST_WD_VALUE);
    rd(`SWE_OFS_PIN_CTRL, `SWE_RST_PIN_CTRL);
    rd(8'h7f, 8'h00);
    sel <= 6'h01; // first either-edge pin sits on gpio bit 1
    idle(2);
    gin[1] <= 1'b1;
    idle(3);
    rd(`SWE_OFS_MISC_STS, 8'h01);
    rd(`SWE_OFS_SMI_STS3, 8'h02);
    swe_host_model_inst.wr(`SWE_OFS_MISC_STS, 8'h01);
    rd(`SWE_OFS_MISC_STS, 8'h00);
    gin[1] <= 1'b0;
    idle(3);
    rd(`SWE_OFS_MISC_STS, 8'h01);
    @(negedge mclk);
    check(8'(rb[0]), 8'(gin[1] ^ gpol[1]));
    check(8'(ovr), 8'h01);
    swe_host_model_inst.wr(`SWE_OFS_SMI_STS3, 8'hff);
    gin[3] <= 1'b1;
    idle(3);
    rd(`SWE_OFS_SMI_STS3, {4'h0, ~p, 3'h0});
    swe_host_model_inst.wr(`SWE_OFS_SMI_STS3, 8'h08);
    gin[3] <= 1'b0;
    idle(3);
    rd(`SWE_OFS_SMI_STS3, {4'h0, p, 3'h0});
    swe_host_model_inst.wr(`SWE_OFS_SMI_STS3, 8'hff);
    swe_host_model_inst.wr(`SWE_OFS_SMI_EN3, 8'h02);
    swe_host_model_inst.wr(`SWE_OFS_SMI_EN2, 8'hc0);
    gin[1] <= 1'b1;
    @(negedge mclk);
    check(8'(grp), 8'h00);
    idle(3);
    @(negedge mclk);
    check(8'({grp, pout, poe, sirq}), 8'h0b);
    swe_host_model_inst.wr(`SWE_OFS_SMI_EN2, 8'he0);
    idle(2);
    @(negedge mclk);
    check(8'(devint), 8'h01);
    swe_host_model_inst.wr(`SWE_OFS_WAKE_EN, 8'h01);
    @(negedge mclk);
    check(8'(wake), 8'h01);
    @(posedge mclk);
    sel <= 6'h00;
    @(negedge mclk);
    check(8'({wake, grp}), 8'h00);
    swe_host_model_inst.wr(`SWE_OFS_WD_UNITS, 8'h00);
    swe_host_model_inst.wr(`SWE_OFS_WD_CONFIG, 8'h11);
    swe_host_model_inst.wr(`SWE_OFS_WD_VALUE, 8'h03);
    idle(5);
    rd(`SWE_OFS_WD_CONTROL, 8'h00);
    idle(40);
    rd(`SWE_OFS_WD_CONTROL, 8'h01);
    @(negedge mclk);
    check(8'({wchan, wirq}), 8'h03);
    idle(1);
    kbd_ev <= 1'b1;
    idle(1);
    kbd_ev <= 1'b0;
    rd(`SWE_OFS_WD_CONTROL, 8'h00);
    swe_host_model_inst.wr(`SWE_OFS_WD_CONTROL, 8'h04);
    rd(`SWE_OFS_WD_CONTROL, 8'h01);
    swe_host_model_inst.wr(`SWE_OFS_WD_CONTROL, 8'h00);
    rd(`SWE_OFS_WD_CONTROL, 8'h00);
    swe_host_model_inst.wr(`SWE_OFS_WD_CONTROL, 8'h01);
    rd(`SWE_OFS_WD_CONTROL, 8'h01);
    swe_host_model_inst.wr(`SWE_OFS_WD_CONTROL, 8'h00);
    swe_host_model_inst.wr(`SWE_OFS_WD_VALUE, 8'h02);
    swe_host_model_inst.wr(`SWE_OFS_WD_VALUE, 8'h00);
    idle(40);
    rd(`SWE_OFS_WD_CONTROL, 8'h00);
    rd(`SWE_OFS_WD_VALUE, 8'h00);
    idle(2);
    conclude();
  end
endmodule
`default_nettype wire
